// ===== logic/arc_regs.svh
// constants for the converter result coding and gain control block
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_RES_W 12
`define ARC_GAIN_W 3
`define ARC_CTL_BIP_BIT 9
`define ARC_CTL_DIF_BIT 10
`define ARC_CTL_DUAL_BIT 0
`define ARC_PWR_AMP_BIT 3
`define ARC_UNI_MAX 12'hfff
`define ARC_UNI_MIN 12'h000
`define ARC_BIP_MAX 12'h7ff
`define ARC_BIP_MIN 12'h800
`define ARC_GAIN_CAP 12'ha3d
`define ARC_GAIN_UNITY 3'h0
`define ARC_GAIN_TOP 3'h5
`define ARC_SETTLE_CYC 40
`define ARC_ACQ_CYC 3
`define ARC_PWRUP_CYC 10
`define ARC_CONV_CYC 13
`define ARC_WARMUP_NS 5000
`define ARC_CLK_NS 10
`define ARC_WARMUP_CYC ((`ARC_WARMUP_NS + `ARC_CLK_NS - 1) / `ARC_CLK_NS)
`endif

// ===== logic/arc_pkg.sv
// types for the converter result coding and gain control block
package arc_pkg;
   typedef enum logic [2:0] {
      ARC_OFF, ARC_PWRUP, ARC_SETTLE, ARC_ACQ, ARC_TRACK, ARC_CONV
   } arc_state_t;
   typedef struct packed {
      logic conv_enable;
      logic amp_enable_bit;
      logic [2:0] gain_select_field;
   } arc_power_t;
   typedef struct packed {
      logic differential_select;
      logic bipolar_select;
      logic dual_edge_select;
   } arc_ctrl_t;
   typedef struct packed {
      logic [11:0] raw;
      logic over;
      logic under;
   } arc_core_t;
endpackage

// ===== logic/arc_coder.sv
// formats one raw converter word into the output code
`timescale 1ns/10ps
`include "arc_regs.svh"
module arc_coder (
   input wire arc_pkg::arc_core_t core,
   input wire logic bipolar,
   input wire logic [2:0] gain,
   output logic [11:0] code
);
   always_comb begin
      if (core.over) begin
         code = bipolar ? `ARC_BIP_MAX : `ARC_UNI_MAX;
      end else if (core.under) begin
         code = bipolar ? `ARC_BIP_MIN : `ARC_UNI_MIN;
      end else if (bipolar) begin
         // offset-binary core word to two's complement
         code = {~core.raw[11], core.raw[10:0]};
      end else if (gain != `ARC_GAIN_UNITY
                   && core.raw > `ARC_GAIN_CAP) begin
         code = `ARC_GAIN_CAP;
      end else begin
         code = core.raw;
      end
   end
endmodule

// ===== logic/arc_ctrl.sv
// sequencer and result register for the gain amplifier and converter
//
// Overview of operation
// - unipolar gives straight binary 0 to 4095
// - bipolar gives two's complement -2048 to 2047
// - result is 12 bits, bit 11 msb
// - unipolar gain above one caps in-range words at 2621
// - overrange forces fff or 7ff
// - underrange forces 000 or 800
// - gain codes 0 to 5 mean x1 to x32
// - gain code zero bypasses the amplifier
// - in single-edge mode gain two or more adds 40 settling cycles
// - amplifier needs 5 us warm-up after enable
// - single-edge mode times its own intervals
// - unity gain conversion fits 2 us
// - bipolar select lives at control bit 9
// - differential select lives at control bit 10
// - converter enable cleared powers everything down except the warm-up timer, so amp_warm keeps following the amp enable bit
// - dual-edge: rise acquires, fall converts
`timescale 1ns/10ps
`include "arc_regs.svh"
module arc_ctrl #(
   parameter int WARMUP_CYC = `ARC_WARMUP_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic conv_tick,
   input wire logic [15:0] converter_control_reg,
   input wire logic [7:0] analog_power_enable_reg,
   input wire logic conv_enable,
   input wire logic [2:0] gain_select_field,
   input wire logic start_level,
   input wire arc_pkg::arc_core_t core_word,
   output logic [11:0] conv_result_bits,
   output logic result_ready,
   output logic amp_bypass,
   output logic amp_powered,
   output logic amp_warm,
   output logic [5:0] gain_factor_value,
   output logic track,
   output logic conv_busy,
   output logic sample_pulse
);
   arc_pkg::arc_ctrl_t ctl;
   arc_pkg::arc_power_t pwr;
   arc_pkg::arc_state_t state, next_state;
   logic [6:0] cnt, next_cnt;
   logic [12:0] warm, next_warm;
   logic start_d, next_start_d;
   logic [11:0] coded;
   logic [11:0] next_result;
   logic next_ready, next_sample, next_busy, next_track;
   logic next_bypass, next_powered, next_warm_flag;
   logic [5:0] next_gf;
   logic rise, fall, hi_gain;

   assign ctl.bipolar_select = converter_control_reg[`ARC_CTL_BIP_BIT];
   assign ctl.differential_select =
      converter_control_reg[`ARC_CTL_DIF_BIT];
   assign ctl.dual_edge_select = converter_control_reg[`ARC_CTL_DUAL_BIT];
   assign pwr.conv_enable = conv_enable;
   assign pwr.amp_enable_bit = analog_power_enable_reg[`ARC_PWR_AMP_BIT];
   assign pwr.gain_select_field = gain_select_field;
   assign hi_gain = pwr.gain_select_field != `ARC_GAIN_UNITY;
   assign rise = start_level & ~start_d;
   assign fall = ~start_level & start_d;

   arc_coder u_coder (
      .core(core_word),
      .bipolar(ctl.bipolar_select),
      .gain(pwr.gain_select_field),
      .code(coded)
   );

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_result = conv_result_bits;
      next_ready = 1'b0;
      next_sample = 1'b0;
      next_start_d = conv_tick ? start_level : start_d;
      next_warm = warm;
      // warm-up runs on mclk so it is exact in time, not in ticks
      if (!pwr.amp_enable_bit) begin
         next_warm = '0;
      end else if (warm < 13'(WARMUP_CYC)) begin
         next_warm = warm + 13'd1;
      end
      if (!pwr.conv_enable) begin
         next_state = arc_pkg::ARC_OFF;
         next_cnt = '0;
      end else if (conv_tick) begin
         unique case (state)
            arc_pkg::ARC_OFF: begin
               if (rise) begin
                  next_state = arc_pkg::ARC_PWRUP;
                  next_cnt = 7'(`ARC_PWRUP_CYC - 1);
               end
            end
            arc_pkg::ARC_PWRUP: begin
               if (cnt != '0) begin
                  next_cnt = cnt - 7'd1;
               end else if (ctl.dual_edge_select) begin
                  next_state = arc_pkg::ARC_TRACK;
               end else if (hi_gain) begin
                  next_state = arc_pkg::ARC_SETTLE;
                  next_cnt = 7'(`ARC_SETTLE_CYC - 1);
               end else begin
                  next_state = arc_pkg::ARC_ACQ;
                  next_cnt = 7'(`ARC_ACQ_CYC - 1);
               end
            end
            arc_pkg::ARC_SETTLE: begin
               if (cnt != '0) begin
                  next_cnt = cnt - 7'd1;
               end else begin
                  next_state = arc_pkg::ARC_ACQ;
                  next_cnt = 7'(`ARC_ACQ_CYC - 1);
               end
            end
            arc_pkg::ARC_ACQ: begin
               if (cnt != '0) begin
                  next_cnt = cnt - 7'd1;
               end else begin
                  next_state = arc_pkg::ARC_CONV;
                  next_cnt = 7'(`ARC_CONV_CYC - 1);
                  next_sample = 1'b1;
               end
            end
            arc_pkg::ARC_TRACK: begin
               // the trigger party owns the track length
               if (fall) begin
                  next_state = arc_pkg::ARC_CONV;
                  next_cnt = 7'(`ARC_CONV_CYC - 1);
                  next_sample = 1'b1;
               end
            end
            arc_pkg::ARC_CONV: begin
               if (cnt != '0) begin
                  next_cnt = cnt - 7'd1;
               end else begin
                  next_result = coded;
                  next_ready = 1'b1;
                  next_state = arc_pkg::ARC_OFF;
               end
            end
         endcase
      end
      next_busy = next_state != arc_pkg::ARC_OFF;
      next_track = next_state == arc_pkg::ARC_TRACK
                || next_state == arc_pkg::ARC_ACQ
                || next_state == arc_pkg::ARC_SETTLE;
      next_bypass = !hi_gain;
      next_powered = pwr.amp_enable_bit && pwr.conv_enable;
      next_warm_flag = pwr.amp_enable_bit && warm >= 13'(WARMUP_CYC);
      next_gf = hi_gain && pwr.gain_select_field <= `ARC_GAIN_TOP
              ? 6'(6'd1 << pwr.gain_select_field) : 6'd1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= arc_pkg::ARC_OFF;
         cnt <= '0;
         warm <= '0;
         start_d <= 1'b0;
         conv_result_bits <= '0;
         result_ready <= 1'b0;
         sample_pulse <= 1'b0;
         conv_busy <= 1'b0;
         track <= 1'b0;
         amp_bypass <= 1'b1;
         amp_powered <= 1'b0;
         amp_warm <= 1'b0;
         gain_factor_value <= 6'h01;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         warm <= next_warm;
         start_d <= next_start_d;
         conv_result_bits <= next_result;
         result_ready <= next_ready;
         sample_pulse <= next_sample;
         conv_busy <= next_busy;
         track <= next_track;
         amp_bypass <= next_bypass;
         amp_powered <= next_powered;
         amp_warm <= next_warm_flag;
         gain_factor_value <= next_gf;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence settle_run_s;
      state == arc_pkg::ARC_SETTLE && cnt == 7'd0 && conv_tick;
   endsequence

   result_held_a: assert property (
      !result_ready |-> conv_result_bits == $past(conv_result_bits)
   ) else $error("result changed without ready");
   over_code_a: assert property (
      state == arc_pkg::ARC_CONV && cnt == 0 && conv_tick && conv_enable
      && core_word.over && ctl.bipolar_select
      |=> conv_result_bits == 12'h7ff
   ) else $error("bipolar overrange code wrong");
   under_code_a: assert property (
      state == arc_pkg::ARC_CONV && cnt == 0 && conv_tick && conv_enable
      && core_word.under && !core_word.over && !ctl.bipolar_select
      |=> conv_result_bits == 12'h000
   ) else $error("unipolar underrange code wrong");
   gain_cap_a: assert property (
      result_ready && !ctl.bipolar_select && hi_gain
      && $stable(converter_control_reg) && $stable(gain_select_field)
      |-> conv_result_bits <= 12'd2621
   ) else $error("gain cap exceeded");
   settle_to_acq_a: assert property (
      settle_run_s and conv_enable |=> state == arc_pkg::ARC_ACQ
   ) else $error("settling did not lead to acquisition");
   power_down_a: assert property (
      !conv_enable |=> state == arc_pkg::ARC_OFF && !conv_busy
   ) else $error("converter ran while disabled");
   dual_fall_a: assert property (
      state == arc_pkg::ARC_TRACK && conv_tick && fall && conv_enable
      |=> state == arc_pkg::ARC_CONV ##0 sample_pulse
   ) else $error("falling edge did not start conversion");
   bypass_a: assert property (
      gain_select_field == 3'h0 [*2] |-> amp_bypass
   ) else $error("unity gain not bypassed");
   warm_a: assert property (
      !analog_power_enable_reg[`ARC_PWR_AMP_BIT] |=> !amp_warm
   ) else $error("amplifier warm while disabled");
endmodule

// ===== dv/arc_core_model.sv
// analog core stand-in: converter clock enable and raw result word
`timescale 1ns/10ps
module arc_core_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic busy,
   input wire arc_pkg::arc_core_t value,
   output logic conv_tick,
   output arc_pkg::arc_core_t core_word
);
   // converter clock is mclk divided by two
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) conv_tick <= 1'b0;
      else conv_tick <= ~conv_tick;
   end
   // outside a conversion the word is not valid, so show its inverse
   assign core_word = busy ? value : ~value;
endmodule

// ===== dv/arc_ctrl_tb_top.sv
// self-checking bench for the converter sequencer and result coder
`timescale 1ns/10ps
module arc_ctrl_tb_top;
   logic mclk, rst_n, tick, en, start, ready, byp, pwr, warm, trk, busy, smp;
   logic [15:0] ctl;
   logic [7:0] pwr_reg;
   logic [2:0] gain;
   logic [11:0] res;
   logic [5:0] gf;
   arc_pkg::arc_core_t val, word;
   int err_total, n_tests, t_uni, t_gain, n;
   arc_core_model model (.mclk(mclk), .rst_n(rst_n), .busy(busy),
      .value(val), .conv_tick(tick), .core_word(word));
   arc_ctrl #(.WARMUP_CYC(8)) uut (.mclk(mclk), .rst_n(rst_n),
      .conv_tick(tick), .converter_control_reg(ctl),
      .analog_power_enable_reg(pwr_reg), .conv_enable(en),
      .gain_select_field(gain), .start_level(start), .core_word(word),
      .conv_result_bits(res), .result_ready(ready), .amp_bypass(byp),
      .amp_powered(pwr), .amp_warm(warm), .gain_factor_value(gf),
      .track(trk), .conv_busy(busy), .sample_pulse(smp));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one single-edge conversion; flip swaps coding mode mid-way
   task automatic conv(input logic [13:0] w, input logic [11:0] exp,
                       input logic flip, output int ticks);
      logic [11:0] prev, mid;
      int k;
      step(4);
      prev = res;
      mid = res;
      val = w;
      start = 1'b1;
      ticks = 0;
      for (k = 0; k < 400; k++) begin
         step(1);
         if (ready === 1'b1) break;
         if (tick === 1'b1) ticks++;
         if (tick === 1'b1 && ticks == 20) begin
            mid = res;
            ctl[9] = ctl[9] ^ flip;
         end
      end
      // a sequence that never finishes counts as a mismatch
      chk({11'h0, ready}, 12'h001);
      chk(mid, prev);
      chk(res, exp);
      start = 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      en = 1'b1;
      start = 1'b0;
      ctl = 16'h0400; // differential pairs selected
      pwr_reg = 8'h00;
      gain = 3'h0;
      val = '0;
      err_total = 0;
      n_tests = 0;
      repeat (6) @(posedge mclk);
      #1 rst_n = 1'b1;
      for (n = 0; n < 2; n++) begin
         ctl[9] = n[0];
         conv(14'h3ffc, 12'hfff ^ {n[0], 11'h0}, 1'b0, t_uni);
         conv(14'h0000, {n[0], 11'h0}, 1'b0, t_uni);
         conv(14'h2004, 12'h801 ^ {n[0], 11'h0}, 1'b0, t_uni);
         conv(14'h048f, n[0] ? 12'h7ff : 12'hfff, 1'b0, t_uni);
         conv(14'h1159, n[0] ? 12'h800 : 12'h000, 1'b0, t_uni);
      end
      ctl[9] = 1'b0;
      chk({6'h0, gf}, 12'h001);
      chk({11'h0, byp}, 12'h001);
      pwr_reg[3] = 1'b1;
      step(2);
      chk({10'h0, pwr, warm}, 12'h002);
      step(10);
      chk({11'h0, warm}, 12'h001);
      for (n = 1; n < 8; n++) begin
         gain = n[2:0];
         conv(14'h3ffc, 12'ha3d, 1'b0, t_gain);
         chk({6'h0, gf}, n < 6 ? 12'(1 << n) : 12'h001);
         chk({11'h0, byp}, 12'h000);
      end
      conv(14'h28f0, 12'ha3c, 1'b0, t_gain);
      chk(12'(t_gain - t_uni), 12'd40);
      // amplifier off alone must not bypass it
      pwr_reg[3] = 1'b0;
      step(2);
      chk({11'h0, byp}, 12'h000);
      pwr_reg[3] = 1'b1;
      // power-up, acquisition and conversion fit 28 converter clocks at unity
      chk({11'h0, t_uni > 28}, 12'h000);
      gain = 3'h0;
      conv(14'h2400, 12'h100, 1'b1, t_uni);
      ctl[9] = 1'b0;
      step(4);
      start = 1'b1;
      step(40);
      en = 1'b0;
      step(2);
      chk({10'h0, busy, pwr}, 12'h000);
      n = 0;
      repeat (200) begin
         step(1);
         if (ready === 1'b1) n++;
      end
      chk(12'(n), 12'h000);
      en = 1'b1;
      start = 1'b0;
      // dual edge skips settling even above unity gain
      gain = 3'h1;
      ctl[0] = 1'b1;
      step(4);
      val = 14'h0c84;
      start = 1'b1;
      step(400); // trigger holds acquisition well past settling
      chk({10'h0, trk, busy}, 12'h003);
      start = 1'b0;
      n = 0;
      repeat (100) begin
         step(1);
         if (smp === 1'b1) n = 1;
         if (ready === 1'b1) break;
      end
      chk({11'h0, ready}, 12'h001);
      chk(res, 12'h321);
      chk(12'(n), 12'h001);
      wrap_up();
   end
endmodule
